// ### hdl/solicit_match_pkg.sv
// Purpose: shared constants and carriers for the solicitation address matcher
// Assumes: apb with 32-bit data, byte addresses
// Notes:   offsets are byte addresses of the least significant word of each address
package solicit_match_pkg;

  localparam int unsigned ENTRIES          = 2;
  localparam int unsigned ADDR_W           = 12;
  localparam int unsigned WORDS_PER_ADDR   = 4;

  localparam logic [11:0] WAKE_CTRL2_OFS   = 12'h600;
  localparam logic [11:0] ENTRY0_DEST_OFS  = 12'h610;
  localparam logic [11:0] ENTRY0_SRC_OFS   = 12'h620;
  localparam logic [11:0] ENTRY0_TGTA_OFS  = 12'h630;
  localparam logic [11:0] ENTRY0_TGTB_OFS  = 12'h640;
  localparam logic [11:0] ENTRY1_DEST_OFS  = 12'h650;
  localparam logic [11:0] ENTRY1_SRC_OFS   = 12'h660;
  localparam logic [11:0] ENTRY1_TGTA_OFS  = 12'h670;
  localparam logic [11:0] ENTRY1_TGTB_OFS  = 12'h680;
  localparam logic [11:0] ADDR_TABLE_BASE  = 12'h610;
  localparam logic [11:0] ADDR_TABLE_END   = 12'h68C;
  localparam logic [11:0] MATCH_STATUS_OFS = 12'h6C0;

  localparam int unsigned OFFLOAD_EN_BIT   = 3;
  localparam int unsigned RECEIVED_BIT     = 7;
  localparam logic [31:0] WAKE_CTRL2_RW_MASK = 32'h0000_0008;
  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;

  // solicited-node multicast prefix ff02::1:ff00:0/104
  localparam logic [103:0] SNODE_PREFIX    = 104'hFF02_0000_0000_0000_0000_0001_FF;
  localparam int unsigned  SNODE_KEEP      = 24;

  // one received packet as offered by the receive parser; all addresses in
  // wire order: first received byte in bits 127:120
  typedef struct packed {
    logic         valid;
    logic         eth_dest_is_own;
    logic         eth_dest_is_multicast;
    logic         eth_dest_is_broadcast;
    logic         is_ipv6;
    logic         is_solicitation;
    logic         frame_good;
    logic [127:0] ip_dest;
    logic [127:0] ip_src;
    logic [127:0] target;
  } rx_packet_t;

  typedef struct packed {
    logic       match;
    logic       entry;
    logic       target_b;
  } match_result_t;

  typedef enum logic [0:0] {IDLE, REPORT} match_state_t;

endpackage : solicit_match_pkg

// ### hdl/solicit_address_matcher.sv
// Purpose: neighbor solicitation address matcher with apb register file
// Assumes: receive parser presents one whole packet summary per valid cycle
// Notes:   result appears two cycles after the packet; apb answers with no wait
//
// How it works
// - compare only while offload enable set
// - own, multicast or broadcast frames only
// - compare each entry's destination with header
// - solicited-node destination compares header low 24 with entry bits 127:104
// - compare each entry's source with header
// - all-zero source is wildcard match
// - header-matched entries compare target against both
// - all-zero target disables that compare
// - four words, lowest offset bits 31:0
// - first received byte lands bits 127:120
// - same byte order for every address
// - offload enable is bit 3, reset zero
// - received flag bit 7, write-one-clear
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module solicit_address_matcher
  import solicit_match_pkg::*;
(
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [31:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  input  wire logic [3:0]                       pstrb,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire solicit_match_pkg::rx_packet_t    rx_pkt,
  output solicit_match_pkg::match_result_t      match_out,
  output logic                                  solicit_offload_enable
);
  import solicit_match_pkg::*;

  // words of the address table: entry*16 + kind*4 + word
  logic [31:0]      table_reg [0:ENTRIES*16-1];
  logic [31:0]      wake_ctrl2_reg;
  logic [31:0]      prdata_next;
  logic             pslverr_next;
  logic             access;
  logic             wr_en;
  logic [11:0]      ofs;
  logic             in_table;
  logic [4:0]       tbl_idx;
  logic             ctrl_wr;
  logic             stage_valid_reg;
  logic [ENTRIES-1:0] hdr_match_reg;
  logic [127:0]     target_reg;
  match_state_t     state_reg;
  match_result_t    result_next;
  logic             received_set;
  logic [31:0]      status_reg;

  assign ofs      = paddr[11:0];
  assign access   = psel && penable;
  assign wr_en    = access && pwrite;
  assign in_table = (paddr[31:12] == 20'h00000) && (ofs >= ADDR_TABLE_BASE)
                    && (ofs <= ADDR_TABLE_END) && (ofs[1:0] == 2'b00);
  assign tbl_idx  = 5'((ofs - ADDR_TABLE_BASE) >> 2);
  // full address decode so that aliases above 0xFFF never reach the control bits
  assign ctrl_wr  = wr_en && (paddr[31:12] == 20'h00000) && (ofs == WAKE_CTRL2_OFS)
                    && pstrb[0];

  // words are held lowest offset = bits 31:0, so wire order needs no swapping
  function automatic logic [127:0] addr_of(input int unsigned base);
    addr_of = {table_reg[base+3], table_reg[base+2],
               table_reg[base+1], table_reg[base]};
  endfunction : addr_of

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      merge_bytes[b*8 +: 8] = strb[b] ? new_w[b*8 +: 8] : old_w[b*8 +: 8];
    end
  endfunction : merge_bytes

  // address table write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ENTRIES*16; i++) begin
        table_reg[i] <= RESET_WORD;
      end
    end else if (wr_en && in_table) begin
      table_reg[tbl_idx] <= merge_bytes(table_reg[tbl_idx], pwdata, pstrb);
    end
  end

  // control register: enable is plain r/w, received flag is set-wins w1c
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ctrl2_reg <= RESET_WORD;
    end else begin
      if (ctrl_wr) begin
        wake_ctrl2_reg[OFFLOAD_EN_BIT] <= pwdata[OFFLOAD_EN_BIT];
      end
      if (received_set) begin
        wake_ctrl2_reg[RECEIVED_BIT] <= 1'b1;
      end else if (ctrl_wr && pwdata[RECEIVED_BIT]) begin
        wake_ctrl2_reg[RECEIVED_BIT] <= 1'b0;
      end
    end
  end

  // read mux; unmapped addresses read zero with pslverr
  always_comb begin
    prdata_next  = RESET_WORD;
    pslverr_next = 1'b0;
    if (in_table) begin
      prdata_next = table_reg[tbl_idx];
    end else if (paddr[31:12] == 20'h00000 && ofs == WAKE_CTRL2_OFS) begin
      prdata_next = wake_ctrl2_reg & (WAKE_CTRL2_RW_MASK | (32'h1 << RECEIVED_BIT));
    end else if (paddr[31:12] == 20'h00000 && ofs == MATCH_STATUS_OFS) begin
      prdata_next = status_reg;
    end else begin
      pslverr_next = 1'b1;
    end
  end

  // zero-wait slave: pready is set at the edge ending the setup cycle so the access phase ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= RESET_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? prdata_next : RESET_WORD;
      pslverr <= psel && !penable && pslverr_next;
    end
  end

  // stage 1: header compare per entry
  function automatic logic dest_hit(input logic [127:0] prog, input logic [127:0] hdr);
    if (hdr[127:24] == SNODE_PREFIX) begin
      dest_hit = (prog[127:104] == hdr[23:0]);
    end else begin
      dest_hit = (prog == hdr);
    end
  endfunction : dest_hit

  logic eligible;
  assign eligible = rx_pkt.valid && rx_pkt.is_ipv6 && rx_pkt.is_solicitation
                    && rx_pkt.frame_good
                    && wake_ctrl2_reg[OFFLOAD_EN_BIT]
                    && (rx_pkt.eth_dest_is_own || rx_pkt.eth_dest_is_multicast
                        || rx_pkt.eth_dest_is_broadcast);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_valid_reg <= 1'b0;
      hdr_match_reg   <= '0;
      target_reg      <= '0;
    end else begin
      stage_valid_reg <= eligible;
      target_reg      <= rx_pkt.target;
      for (int e = 0; e < ENTRIES; e++) begin
        hdr_match_reg[e] <= eligible
          && dest_hit(addr_of(e*16), rx_pkt.ip_dest)
          && ((addr_of(e*16+4) == '0)
              || (addr_of(e*16+4) == rx_pkt.ip_src));
      end
    end
  end

  // stage 2: target compare against both target registers of matched entries
  function automatic logic tgt_hit(input logic [127:0] prog, input logic [127:0] tgt);
    tgt_hit = (prog != '0) && (prog == tgt);
  endfunction : tgt_hit

  always_comb begin
    result_next = '0;
    for (int e = ENTRIES-1; e >= 0; e--) begin
      if (stage_valid_reg && hdr_match_reg[e]) begin
        if (tgt_hit(addr_of(e*16+8), target_reg)) begin
          result_next = '{match: 1'b1, entry: 1'(e), target_b: 1'b0};
        end else if (tgt_hit(addr_of(e*16+12), target_reg)) begin
          result_next = '{match: 1'b1, entry: 1'(e), target_b: 1'b1};
        end
      end
    end
  end

  assign received_set = result_next.match;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_out <= '0;
      state_reg <= IDLE;
    end else begin
      match_out <= result_next;
      case (state_reg)
        IDLE:    state_reg <= result_next.match ? REPORT : IDLE;
        REPORT:  state_reg <= result_next.match ? REPORT : IDLE;
        default: state_reg <= IDLE;
      endcase
    end
  end

  // last match kept for software: bit0 matched, bit1 entry, bit2 target b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= RESET_WORD;
    end else if (result_next.match) begin
      status_reg <= {29'h0, result_next.target_b, result_next.entry, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      solicit_offload_enable <= 1'b0;
    end else begin
      solicit_offload_enable <= wake_ctrl2_reg[OFFLOAD_EN_BIT];
    end
  end

endmodule : solicit_address_matcher
`default_nettype wire

// ### test/solicit_matcher_sva.sv
// Purpose: port checks for the solicitation matcher
// Assumes: zero wait apb, match two edges after a packet
// Notes: attached by the bind below
`timescale 1ns/1ps
`default_nettype none
module solicit_matcher_sva
  import solicit_match_pkg::*;
(
  input wire logic                            pclk,
  input wire logic                            presetn,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic [31:0]                     paddr,
  input wire logic [31:0]                     prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  input wire solicit_match_pkg::rx_packet_t    rx_pkt,
  input wire solicit_match_pkg::match_result_t match_out,
  input wire logic                            solicit_offload_enable
);
  wire logic eth_ok = rx_pkt.eth_dest_is_own | rx_pkt.eth_dest_is_multicast
                    | rx_pkt.eth_dest_is_broadcast;
  wire logic kind_ok = rx_pkt.is_ipv6 & rx_pkt.is_solicitation & rx_pkt.frame_good;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  bad_addr_a: assert property (psel && !penable && paddr[31:12] != 0 |=> pslverr)
    else $error("unmapped address accepted");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  // the enable copy lags the bit by one edge, the match by two edges
  enable_gate_a: assert property (match_out.match |-> $past(solicit_offload_enable))
    else $error("match while disabled");
  eth_gate_a: assert property (rx_pkt.valid && !eth_ok |-> ##2 !match_out.match)
    else $error("match on foreign frame");
  kind_gate_a: assert property (rx_pkt.valid && !kind_ok |-> ##2 !match_out.match)
    else $error("match on wrong packet kind");
  match_cause_a: assert property (match_out.match |-> $past(rx_pkt.valid, 2))
    else $error("match without packet");
endmodule : solicit_matcher_sva
bind solicit_address_matcher solicit_matcher_sva chk (.pclk, .presetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .rx_pkt, .match_out, .solicit_offload_enable);
`default_nettype wire

// ### test/rx_parser_model.sv
// Purpose: receive parser stand-in, one packet summary per request
// Assumes: go is high one cycle with pkt held
// Notes: idle cycles invert the fields so stale addresses never pass
`timescale 1ns/1ps
`default_nettype none
module rx_parser_model
  import solicit_match_pkg::*;
(
  input  wire logic                          pclk,
  input  wire logic                          go,
  input  wire solicit_match_pkg::rx_packet_t pkt,
  output solicit_match_pkg::rx_packet_t      rx_pkt
);
  // idle cycles show the inverse of the last offer, valid low, in one assignment
  always @(posedge pclk) begin
    rx_pkt <= go ? pkt : rx_packet_t'({1'b0, ~pkt[$bits(pkt)-2:0]});
  end
endmodule : rx_parser_model
`default_nettype wire

// ### test/tb_solicit_address_matcher.sv
// Purpose: self-checking bench for the matcher
// Assumes: zero wait apb
// Notes: results queue up, a monitor pops them
`timescale 1ns/1ps
`default_nettype none
module tb_solicit_address_matcher;
  import solicit_match_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, lf = 32'h0001_755B;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, solicit_offload_enable;
  rx_packet_t pkt = '0, rx_pkt;
  match_result_t match_out, m_q[$];
  logic [32:0] rd_q[$];
  logic [127:0] d0, t0, d1, s1, t1;
  int fails = 0, total_checks = 0;
  always #2.5 pclk = ~pclk;
  solicit_address_matcher dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_pkt, .match_out,
    .solicit_offload_enable);
  rx_parser_model model (.pclk, .go, .pkt, .rx_pkt);
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic rnd(output logic [127:0] v);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr_next(lf);
      v[32*i+:32] = lf;
    end
  endtask : rnd
  task automatic cmp_rd(input logic [32:0] e, g);
    total_checks++;
    if (e !== g) begin
      fails++;
      $display("[ERR] apb read exp %h seen %h", e, g);
    end
  endtask : cmp_rd
  task automatic cmp_m(input match_result_t e, g);
    total_checks++;
    if (e !== g) begin
      fails++;
      $display("[ERR] match_out exp %b seen %b", e, g);
    end
  endtask : cmp_m
  always @(posedge pclk) if (presetn) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp_rd(rd_q.pop_front(), {pslverr, prdata});
    if (match_out.match !== 1'b0)
      cmp_m(m_q.size() ? m_q.pop_front() : '0, match_out);
  end
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] e = '0);
    if (!w) rd_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic w128(input logic [31:0] b, input logic [127:0] v);
    for (int i = 0; i < 4; i++)
      apb(1'b1, b + 32'(4 * i), v[32*i+:32]);
  endtask : w128
  // flags: own, multicast, broadcast, ipv6, solicitation, good; r: expect + result
  task automatic pk(input logic [5:0] f, input logic [127:0] a, b, c, input logic [3:0] r);
    if (r[3]) m_q.push_back(match_result_t'(r[2:0]));
    @(posedge pclk);
    pkt <= {1'b1, f, a, b, c};
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pk
  task automatic report_and_stop;
    fails += m_q.size();
    fails += rd_q.size();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 32'h600, 0, 33'h0);
    for (int i = 0; i < 32; i++)
      apb(1'b0, 32'h610 + 32'(4 * i), 0, 33'h0);
    apb(1'b1, 32'h1000, 32'hFFFF_FFFF);
    apb(1'b0, 32'h1000, 0, 33'h1_0000_0000);
    // an alias of the control word must not switch the offload on
    apb(1'b1, 32'h1600, 32'h8);
    rnd(d0);
    rnd(t0);
    rnd(d1);
    rnd(s1);
    rnd(t1);
    w128(32'h610, d0);
    w128(32'h630, t0);
    w128(32'h650, d1);
    w128(32'h660, s1);
    w128(32'h680, t1);
    apb(1'b0, 32'h61C, 0, {1'b0, d0[127:96]});
    $display("registers done");
    pk(6'h27, d0, s1, t0, 4'h0);
    apb(1'b1, 32'h600, 32'h8);
    apb(1'b0, 32'h600, 0, 33'h8);
    pk(6'h27, d0, s1, t0, 4'hC);
    apb(1'b0, 32'h600, 0, 33'h88);
    // the enable bit is plain r/w, so the clear write keeps it set
    apb(1'b1, 32'h600, 32'h88);
    apb(1'b0, 32'h600, 0, 33'h8);
    pk(6'h17, d1, s1, t1, 4'hF);
    apb(1'b0, 32'h6C0, 0, 33'h7);
    pk(6'h0F, d1, d0, t1, 4'h0);
    pk(6'h0F, {SNODE_PREFIX, d0[127:104]}, s1, t0, 4'hC);
    pk(6'h27, d0, s1, 128'h0, 4'h0);
    pk(6'h07, d0, s1, t0, 4'h0);
    pk(6'h25, d0, s1, t0, 4'h0);
    $display("packets done");
    pstrb <= 4'h2;
    apb(1'b1, 32'h670, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    apb(1'b0, 32'h670, 0, 33'h0_0000_FF00);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 32'h670, 0, 33'h0);
    apb(1'b0, 32'h600, 0, 33'h0);
    pk(6'h27, d0, s1, t0, 4'h0);
    $display("reset done");
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    report_and_stop;
  end
endmodule : tb_solicit_address_matcher
`default_nettype wire
